//--- core/vss_pkg.sv
// constants for the voltage-code step and enable sequencer
// assumes one 50 MHz clock and an APB master with 32-bit data
package vss_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ        = 50;
  localparam logic [7:0]  SIXTH_LEN_RST  = 8'h10;  // clocks per sixth of a cycle
  localparam int          SAMPLES_PER_CYC = 6;
  localparam logic [1:0]  HALF_WAIT_STROBES = 2'h3; // three sixths = half cycle
  localparam logic [11:0] SS_DELAY_CYC   = 12'h040; // 64 switching cycles
  localparam logic [11:0] SS_COARSE_CYC  = 12'h280; // 640 cycles of 25mV steps
  localparam logic [4:0]  COARSE_PERIOD_M1 = 5'h1f; // 32 cycles per 25mV step
  localparam logic [3:0]  FINE_PERIOD_M1 = 4'hf;    // 16 cycles per 12.5mV step
  localparam logic [1:0]  NL_DELAY_CYC   = 2'h2;    // no-load shutdown delay

  // ----------------------------------------------------------------
  // voltage code decode, reference in 12.5mV units
  // ----------------------------------------------------------------
  localparam logic [5:0]  CODE_LOWEST    = 6'h14;   // code of the lowest level
  localparam logic [5:0]  IDX_OFF_GAP    = 6'h16;   // highest index taken by the off codes
  localparam logic [5:0]  IDX_GAP_WIDTH  = 6'h02;
  localparam logic [7:0]  REF_BASE_STEPS = 8'h43;   // 0.8375V in 12.5mV steps
  localparam logic [5:0]  NOLOAD_CODE_A  = 6'h3f;
  localparam logic [5:0]  NOLOAD_CODE_B  = 6'h3e;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET    = 12'h000;
  localparam logic [11:0] STATUS_OFFSET  = 12'h004;
  localparam int          CTRL_LEN_LSB   = 0;
  localparam int          STAT_STATE_LSB = 0;
  localparam int          STAT_OVL_BIT   = 2;
  localparam int          STAT_OK_BIT    = 3;
  localparam int          STAT_NL_BIT    = 4;
  localparam int          STAT_REF_LSB   = 8;
  localparam int          STAT_TGT_LSB   = 16;

  typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_RAMP, ST_RUN} seq_state_t;

endpackage

//--- core/vid_step_enable_sequencer.sv
// enable gathering, soft start and voltage-code tracking of the reference
// assumes all inputs synchronous to clk_i; analog comparators deliver levels
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps

// Function
// - sample code six times per cycle
// - half-cycle wait, then one 12.5mV step
// - sign reversal during wait cancels step
// - large difference: step at every sample
// - shutdown holds pwm outputs high-impedance
// - stay off until supply valid
// - stay off until threshold enable high
// - logic enable low means shutdown
// - no-load codes shut down, others start
// - two cycles before no-load shutdown
// - over-voltage latch ignores voltage codes
// - all enables true: start immediately
// - output ok after good soft start
// - decode six-bit code into levels
// - soft start: 64-cycle wait then ramp
// - 25mV steps first 640, then 12.5mV
module vid_step_enable_sequencer
  import vss_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // enable conditions and code
  input  wire logic        supply_valid_i,
  input  wire logic        threshold_enable_i,
  input  wire logic        logic_level_enable_i,
  input  wire logic [4:0]  voltage_code_in_i,
  input  wire logic        half_step_code_bit_i,
  // analog monitors
  input  wire logic        ov_trip_i,
  input  wire logic        output_in_window_i,
  // outputs
  output logic             pwm_oe_o,
  output logic             ovp_shutdown_level_o,
  output logic             output_ok_o,
  output logic             output_ok_oe_o,
  output logic [7:0]       ref_level_o,
  output logic             soft_start_o
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] decode_level(input logic [5:0] code);
    logic [5:0] idx;
    idx = CODE_LOWEST - code;
    if (idx > IDX_OFF_GAP)
      idx = idx - IDX_GAP_WIDTH; // skip the two off codes
    decode_level = REF_BASE_STEPS + {2'h0, idx};
  endfunction

  logic [5:0] code_w;
  logic [7:0] target_w;
  logic       noload_w;
  logic       en_all_w;

  assign code_w   = {voltage_code_in_i, half_step_code_bit_i};
  assign target_w = decode_level(code_w);
  assign noload_w = (code_w == NOLOAD_CODE_A) || (code_w == NOLOAD_CODE_B);
  // comparator hysteresis lives in the analog front end
  assign en_all_w = supply_valid_i && threshold_enable_i && logic_level_enable_i;

  // ----------------------------------------------------------------
  // registers and apb
  // ----------------------------------------------------------------
  seq_state_t  state_r;
  logic [7:0]  sixth_len_r;
  logic [7:0]  ref_r;
  logic        ov_latched_r;
  logic        ok_r;
  logic        ovp_shut_r;
  logic [1:0]  nl_cnt_r;
  logic [31:0] prdata_r;
  logic [31:0] status_w;
  logic        ctrl_hit_w;
  logic        stat_hit_w;

  assign ctrl_hit_w = paddr_i == CTRL_OFFSET;
  assign stat_hit_w = paddr_i == STATUS_OFFSET;

  always_comb
  begin
    status_w = 32'h0;
    status_w[STAT_STATE_LSB +: 2] = state_r;
    status_w[STAT_OVL_BIT]        = ov_latched_r;
    status_w[STAT_OK_BIT]         = ok_r;
    status_w[STAT_NL_BIT]         = ovp_shut_r;
    status_w[STAT_REF_LSB +: 8]   = ref_r;
    status_w[STAT_TGT_LSB +: 8]   = target_w;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sixth_len_r <= SIXTH_LEN_RST;
    else if (psel_i && penable_i && pwrite_i && ctrl_hit_w)
      sixth_len_r <= pwdata_i[CTRL_LEN_LSB +: 8];
  end

  // read data captured in the setup cycle, so zero wait states suffice
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prdata_r <= 32'h0;
    else if (psel_i && !penable_i)
      prdata_r <= ctrl_hit_w ? {24'h0, sixth_len_r} : (stat_hit_w ? status_w : 32'h0);
  end

  assign prdata_o  = prdata_r;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !ctrl_hit_w && !stat_hit_w;

  // ----------------------------------------------------------------
  // cycle timing
  // ----------------------------------------------------------------
  logic [7:0] sub_r;
  logic [2:0] sixth_r;
  logic [7:0] len_m1_w;
  logic       strobe_w;
  logic       cyc_tick_w;

  // a length of zero behaves as one clock per sixth
  assign len_m1_w   = (sixth_len_r == 8'h0) ? 8'h0 : sixth_len_r - 8'h1;
  assign strobe_w   = sub_r >= len_m1_w;
  assign cyc_tick_w = strobe_w && (sixth_r == 3'h5);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sub_r   <= 8'h0;
      sixth_r <= 3'h0;
    end
    else if (strobe_w)
    begin
      sub_r   <= 8'h0;
      sixth_r <= (sixth_r == 3'h5) ? 3'h0 : sixth_r + 3'h1;
    end
    else
      sub_r <= sub_r + 8'h1;
  end

  // ----------------------------------------------------------------
  // protection latches
  // ----------------------------------------------------------------
  // only dropping an enable clears the latch; a new trip wins the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ov_latched_r <= 1'b0;
    else if (ov_trip_i)
      ov_latched_r <= 1'b1;
    else if (!en_all_w)
      ov_latched_r <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      nl_cnt_r <= 2'h0;
    else if (!noload_w)
      nl_cnt_r <= 2'h0;
    else if (cyc_tick_w && nl_cnt_r != NL_DELAY_CYC)
      nl_cnt_r <= nl_cnt_r + 2'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ovp_shut_r <= 1'b0;
    else
      ovp_shut_r <= noload_w && (nl_cnt_r == NL_DELAY_CYC);
  end

  // ----------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------
  logic [11:0] cyc_cnt_r;
  logic        start_ok_w;
  logic        stop_w;
  logic        ramp_done_w;

  assign start_ok_w  = en_all_w && !ov_latched_r && !noload_w;
  assign stop_w      = !en_all_w || ov_latched_r || (nl_cnt_r == NL_DELAY_CYC);
  assign ramp_done_w = ref_r >= target_w;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_r <= ST_OFF;
    else
    begin
      case (state_r)
        ST_OFF:
          if (start_ok_w)
            state_r <= ST_DELAY;
        ST_DELAY:
          if (stop_w)
            state_r <= ST_OFF;
          else if (cyc_tick_w && cyc_cnt_r == SS_DELAY_CYC - 12'h1)
            state_r <= ST_RAMP;
        ST_RAMP:
          if (stop_w)
            state_r <= ST_OFF;
          else if (ramp_done_w)
            state_r <= ST_RUN;
        ST_RUN:
          if (stop_w)
            state_r <= ST_OFF;
        default:
          state_r <= ST_OFF;
      endcase
    end
  end

  // counts switching cycles within the delay and the ramp
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_r == ST_OFF || state_r == ST_RUN)
      cyc_cnt_r <= 12'h0;
    else if (state_r == ST_DELAY && cyc_tick_w && cyc_cnt_r == SS_DELAY_CYC - 12'h1)
      cyc_cnt_r <= 12'h0;
    else if (cyc_tick_w && cyc_cnt_r != 12'hfff)
      cyc_cnt_r <= cyc_cnt_r + 12'h1;
  end

  // ----------------------------------------------------------------
  // reference level
  // ----------------------------------------------------------------
  logic       pend_r;
  logic       pend_up_r;
  logic       fast_r;
  logic [1:0] wait_r;
  logic       ramp_step_w;
  logic [7:0] ramp_inc_w;
  logic [7:0] ramp_sum_w;
  logic       above_w;
  logic       below_w;
  logic       far_w;

  assign ramp_step_w = cyc_tick_w && ((cyc_cnt_r < SS_COARSE_CYC)
                       ? (cyc_cnt_r[4:0] == COARSE_PERIOD_M1)
                       : (cyc_cnt_r[3:0] == FINE_PERIOD_M1));
  assign ramp_inc_w  = (cyc_cnt_r < SS_COARSE_CYC) ? 8'h2 : 8'h1;
  assign ramp_sum_w  = ref_r + ramp_inc_w;
  assign above_w     = target_w > ref_r;
  assign below_w     = target_w < ref_r;
  assign far_w       = (target_w > ref_r + 8'h1) || (target_w + 8'h1 < ref_r);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_r     <= 8'h0;
      pend_r    <= 1'b0;
      pend_up_r <= 1'b0;
      fast_r    <= 1'b0;
      wait_r    <= 2'h0;
    end
    else
    begin
      case (state_r)
        ST_RAMP:
        begin
          if (ref_r > target_w)
            ref_r <= target_w;
          else if (ramp_step_w)
            ref_r <= (ramp_sum_w > target_w) ? target_w : ramp_sum_w;
        end
        ST_RUN:
        begin
          if (strobe_w)
          begin
            if (!above_w && !below_w)
            begin
              pend_r <= 1'b0;
              fast_r <= 1'b0;
            end
            else if (far_w || fast_r)
            begin
              // once far, keep stepping without the wait down to equality
              pend_r <= 1'b0;
              fast_r <= far_w;
              ref_r  <= above_w ? ref_r + 8'h1 : ref_r - 8'h1;
            end
            else if (!pend_r)
            begin
              pend_r    <= 1'b1;
              pend_up_r <= above_w;
              wait_r    <= 2'h0;
            end
            else if (pend_up_r != above_w)
              pend_r <= 1'b0;
            else if (wait_r == HALF_WAIT_STROBES - 2'h1)
            begin
              pend_r <= 1'b0;
              ref_r  <= above_w ? ref_r + 8'h1 : ref_r - 8'h1;
            end
            else
              wait_r <= wait_r + 2'h1;
          end
        end
        default:
        begin
          ref_r  <= 8'h0;
          pend_r <= 1'b0;
          fast_r <= 1'b0;
          wait_r <= 2'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ok_r <= 1'b0;
    else
      ok_r <= (state_r == ST_RUN) && !stop_w && output_in_window_i;
  end

  assign pwm_oe_o             = state_r != ST_OFF;
  assign ovp_shutdown_level_o = ovp_shut_r;
  assign output_ok_o          = 1'b0;
  assign output_ok_oe_o       = !ok_r;
  assign ref_level_o          = ref_r;
  assign soft_start_o         = (state_r == ST_DELAY) || (state_r == ST_RAMP);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] strobe_seen_r;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || cyc_tick_w)
      strobe_seen_r <= 3'h0;
    else if (strobe_w)
      strobe_seen_r <= strobe_seen_r + 3'h1;
  end

  sequence s_run_two;
    (state_r == ST_RUN) ##1 (state_r == ST_RUN);
  endsequence

  a_six_strobes: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_tick_w |-> strobe_seen_r == 3'h5)
    else $error("strobe count per cycle wrong");
  a_pwm_hiz_off: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == ST_OFF |-> !pwm_oe_o)
    else $error("pwm driven in shutdown");
  a_supply_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    !supply_valid_i |=> state_r == ST_OFF)
    else $error("running without valid supply");
  a_thresh_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    !threshold_enable_i |=> state_r == ST_OFF)
    else $error("running without threshold enable");
  a_logic_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    !logic_level_enable_i |=> state_r == ST_OFF)
    else $error("running without logic enable");
  a_start_now: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == ST_OFF && start_ok_w) |=> state_r == ST_DELAY)
    else $error("soft start not begun at once");
  a_noload_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r != ST_OFF && en_all_w && !ov_latched_r && nl_cnt_r != NL_DELAY_CYC)
    |=> state_r != ST_OFF)
    else $error("no-load shutdown too early");
  a_ov_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (ov_latched_r && en_all_w) |=> ov_latched_r)
    else $error("over-voltage latch cleared by code");
  a_run_step: assert property (@(posedge clk_i) disable iff (rst_i)
    s_run_two |-> (ref_r == $past(ref_r) || ref_r == $past(ref_r) + 8'h1
                   || ref_r == $past(ref_r) - 8'h1))
    else $error("reference moved by more than one step");
  a_ramp_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == ST_RAMP && $past(state_r) == ST_RAMP && $stable(code_w))
    |-> ref_r <= target_w)
    else $error("reference passed the target");
  a_ok_source: assert property (@(posedge clk_i) disable iff (rst_i)
    !output_ok_oe_o |-> $past(state_r) == ST_RUN && $past(output_in_window_i))
    else $error("output ok without finished soft start");

endmodule

//--- sim/vcode_cpu.sv
// processor model that drives the voltage code pins
// assumes the bench names the wanted code; one code step per period unless told to jump
`timescale 1ns/1ps
module vcode_cpu
#(
  parameter int STEP_CLKS = 40
)
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // request from the bench
  input  wire logic [5:0] want_i,
  input  wire logic       jump_i,
  // code pins, always driven
  output logic      [4:0] code_o,
  output logic            half_o
);
  logic [5:0] cur_r;
  int         cnt_r;

  // jumping breaks the pacing on purpose, only when the bench asks
  always_ff @(posedge clk_i)
  begin
    if (rst_i || jump_i)
    begin
      cur_r <= want_i;
      cnt_r <= 0;
    end
    else if (cnt_r < STEP_CLKS - 1)
      cnt_r <= cnt_r + 1;
    else
    begin
      cnt_r <= 0;
      if (cur_r < want_i)
        cur_r <= cur_r + 6'h01;
      else if (cur_r > want_i)
        cur_r <= cur_r - 6'h01;
    end
  end

  assign {code_o, half_o} = cur_r;
endmodule

//--- sim/test_vid_step_enable_sequencer.sv
// bench for the voltage-code step and enable sequencer
// assumes the package and the code driver model are compiled first
`timescale 1ns/1ps
module test_vid_step_enable_sequencer
  import vss_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sup = 1'b0;
  logic        thr = 1'b0;
  logic        len = 1'b0;
  logic        ov = 1'b0;
  logic        win = 1'b1;
  logic [5:0]  want = 6'h00;
  logic        jump = 1'b1;
  logic [4:0]  code;
  logic        half;
  logic        pwm_oe;
  logic        ovp_lvl;
  logic        ok;
  logic        ok_oe;
  logic        ss;
  logic [7:0]  ref_lvl;
  logic [31:0] rd;
  logic        er;
  int          fail_count = 0;
  int          cmp_count = 0;

  always #10 clk = ~clk;

  vid_step_enable_sequencer vid_step_enable_sequencer_i (
    .clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .supply_valid_i(sup),
    .threshold_enable_i(thr), .logic_level_enable_i(len),
    .voltage_code_in_i(code), .half_step_code_bit_i(half), .ov_trip_i(ov),
    .output_in_window_i(win), .pwm_oe_o(pwm_oe), .ovp_shutdown_level_o(ovp_lvl),
    .output_ok_o(ok), .output_ok_oe_o(ok_oe), .ref_level_o(ref_lvl), .soft_start_o(ss));

  vcode_cpu vcode_cpu_i (
    .clk_i(clk), .rst_i(rst), .want_i(want), .jump_i(jump),
    .code_o(code), .half_o(half));

  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, s);
    end
  endtask

  task automatic nw(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no wait limit here: the watchdog ends a hung transfer
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic ens(input logic s, input logic t, input logic l);
    @(posedge clk);
    sup <= s;
    thr <= t;
    len <= l;
    nw(2);
  endtask

  task automatic code_to(input logic [5:0] c, input int n);
    @(posedge clk);
    want <= c;
    nw(n);
  endtask

  // ----
  // scenarios
  // ----
  task automatic t_regs;
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl reset", 32'h10, rd);
    apb(1'b1, CTRL_OFFSET, 32'h2);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk("ctrl", 32'h2, rd);
    apb(1'b1, STATUS_OFFSET, 32'hff);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status off", 32'h0, {16'h0, rd[15:0]});
    chk("pwm off", 0, pwm_oe);
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 1, er);
    chk("unmapped rd", 0, rd);
    $display("test regs done");
  endtask

  task automatic t_start;
    int n;
    n = 0;
    ens(1'b1, 1'b1, 1'b1); // drivers taken as valid already
    chk("ss", 1, ss);
    chk("ref zero", 0, ref_lvl);
    while (ss === 1'b1 && n < 20000)
    begin
      nw(1);
      n++;
    end
    // 64 idle cycles, 640 at 25mV, 752 (47 steps) at 12.5mV; 12 clocks a cycle
    chk("ss len", 1, n >= 1454 * 12 && n <= 1457 * 12);
    chk("ref", 87, ref_lvl);
    nw(3);
    chk("ok", 0, ok_oe);
    chk("ok pin", 0, ok);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("status run", 32'h0057570b, {8'h0, rd[23:8], 3'h0, rd[4:0]});
    @(posedge clk);
    win <= 1'b0;
    nw(2);
    chk("ok drop", 1, ok_oe);
    @(posedge clk);
    win <= 1'b1;
    nw(2);
    chk("ok back", 0, ok_oe);
    $display("test start done");
  endtask

  task automatic t_track;
    int n;
    n = 0;
    @(posedge clk);
    jump <= 1'b0;
    want <= 6'h01;
    while ({code, half} === 6'h00 && n < 100)
    begin
      nw(1);
      n++;
    end
    nw(3);
    chk("step wait", 87, ref_lvl);
    nw(9);
    chk("step", 86, ref_lvl);
    nw(30);
    chk("held", 86, ref_lvl);
    @(posedge clk);
    jump <= 1'b1;
    code_to(6'h04, 5);
    chk("fast", 1, ref_lvl <= 8'd85);
    nw(4);
    chk("fast end", 83, ref_lvl);
    n = 0;
    code_to(6'h03, 2);
    code_to(6'h05, 2);
    code_to(6'h04, 0);
    repeat (30)
    begin
      nw(1);
      n += (ref_lvl !== 8'd83);
    end
    chk("cancel", 0, n);
    $display("test track done");
  endtask

  task automatic t_enable;
    for (int i = 0; i < 3; i++)
    begin
      ens(i != 0, i != 1, i != 2);
      chk("off pwm", 0, pwm_oe);
      chk("off ok", 1, ok_oe);
      ens(1'b1, 1'b1, 1'b1);
      chk("restart", 1, ss);
    end
    $display("test enable done");
  endtask

  task automatic t_noload;
    for (int i = 0; i < 2; i++)
    begin
      code_to(i ? NOLOAD_CODE_B : NOLOAD_CODE_A, 12);
      chk("nl early", 1, pwm_oe);
      nw(16);
      chk("nl off", 0, pwm_oe);
      chk("nl ovp", 1, ovp_lvl);
      code_to(6'h04, 3);
      chk("nl restart", 1, ss);
      chk("nl ovp clear", 0, ovp_lvl);
    end
    $display("test noload done");
  endtask

  task automatic t_ov;
    @(posedge clk);
    ov <= 1'b1;
    @(posedge clk);
    ov <= 1'b0;
    nw(2);
    chk("ov off", 0, pwm_oe);
    code_to(NOLOAD_CODE_A, 40);
    code_to(6'h04, 40);
    chk("ov held", 0, ss);
    code_to(6'h3d, 2);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk("ov flag", 1, rd[STAT_OVL_BIT]);
    chk("gap target", 8'd88, rd[STAT_TGT_LSB +: 8]);
    ens(1'b1, 1'b1, 1'b0);
    ens(1'b1, 1'b1, 1'b1);
    chk("ov clear", 1, ss);
    $display("test ov done");
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // soft start alone takes about 17500 clocks
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    summarize();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_start();
    t_track();
    t_enable();
    t_noload();
    t_ov();
    summarize();
  end
endmodule
